/* File: hw/fpec_bus_timer.sv */
// Avalon-MM access pacer: stretches each request to a fixed number of cycles.
// Assumes the master holds read/write steady until waitrequest is seen low.
`timescale 1ns/1ps
module fpec_bus_timer (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Request from the bus
  input wire logic req_i,
  // Access completes at this edge
  output logic last_o,
  output logic waitrequest_o
);
  import fpec_pkg::*;

  fpec_bus_st_t st_q;
  logic [1:0] cnt_q;

  // Waitrequest idles high so a new request is never answered in its first cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q <= FPEC_IDLE;
      cnt_q <= 2'h0;
    end else begin
      case (st_q)
        FPEC_IDLE: begin
          if (req_i) begin
            st_q <= FPEC_WAIT;
            cnt_q <= 2'h1;
          end
        end
        FPEC_WAIT: begin
          if (cnt_q == WAIT_LAST - 2'h1) begin
            st_q <= FPEC_DONE;
          end
          cnt_q <= cnt_q + 2'h1;
        end
        FPEC_DONE: begin
          st_q <= FPEC_IDLE;
          cnt_q <= 2'h0;
        end
        default: begin
          st_q <= FPEC_IDLE;
          cnt_q <= 2'h0;
        end
      endcase
    end
  end

  assign last_o = (st_q == FPEC_DONE);
  assign waitrequest_o = (st_q != FPEC_DONE);
endmodule : fpec_bus_timer

/* File: hw/fpec_pkg.sv */
// Package for the flash program/erase control block: offsets, field positions, types.
// Assumes a byte-wide Avalon-MM slave with word-aligned register slots.
package fpec_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_ERR_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_SMALL_SEL = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_LARGE_SEL = 4'hC;
  localparam int unsigned BIT_HW_PERMIT = 7;
  localparam int unsigned BIT_SW_PERMIT = 6;
  localparam int unsigned BIT_ERASE_SETUP = 5;
  localparam int unsigned BIT_PROG_SETUP = 4;
  localparam int unsigned BIT_ERASE_VERIFY = 3;
  localparam int unsigned BIT_PROG_VERIFY = 2;
  localparam int unsigned BIT_ERASE_START = 1;
  localparam int unsigned BIT_PROG_START = 0;
  localparam int unsigned BIT_ERR_FLAG = 7;
  localparam int unsigned LARGE_BLOCKS = 6;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CTRL_PIN_HIGH = 8'h80;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Access cycles counted from the request edge; waitrequest drops on the last.
  localparam int unsigned ACCESS_CYCLES = 3;
  localparam logic [1:0] WAIT_LAST = 2'(ACCESS_CYCLES - 1);

  typedef enum logic [1:0] {
    FPEC_IDLE = 2'b00,
    FPEC_WAIT = 2'b01,
    FPEC_DONE = 2'b11
  } fpec_bus_st_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic byteenable;
    logic [7:0] writedata;
  } fpec_av_req_t;

  typedef struct packed {
    logic program_start;
    logic erase_start;
    logic program_verify;
    logic erase_verify;
    logic program_setup;
    logic erase_setup;
  } fpec_mode_t;
endpackage : fpec_pkg

/* File: hw/fpec_top.sv */
// Flash program/erase mode control registers behind an Avalon-MM slave.
// Assumes pins hw_write_permit and flash_enable come from outside the clock domain;
// standby requests and error events come from same-clock logic.
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module fpec_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [fpec_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_byteenable_i,
  input wire logic [7:0] avs_writedata_i,
  output logic [7:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Device pins and system state
  input wire logic hw_write_permit_i,
  input wire logic flash_enable_i,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic flash_error_event_i,
  // Mode and block select outputs to the array sequencer
  output fpec_pkg::fpec_mode_t mode_o,
  output logic sw_write_permit_o,
  output logic [7:0] small_block_erase_o,
  output logic [fpec_pkg::LARGE_BLOCKS-1:0] large_block_erase_o,
  output logic flash_error_flag_o
);
  import fpec_pkg::*;

  logic [1:0] hw_sync_q;
  logic [1:0] en_sync_q;
  logic hw_permit;
  logic flash_en;
  fpec_av_req_t req;
  logic acc_last;
  logic wait_int;
  logic wr_ok;
  logic rd_ok;
  logic sw_permit_q;
  fpec_mode_t mode_q;
  logic err_flag_q;
  logic [7:0] small_sel_q;
  logic [LARGE_BLOCKS-1:0] large_sel_q;
  logic [7:0] small_sel_d;
  logic [LARGE_BLOCKS-1:0] large_sel_d;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_d;
  logic sel_wr;
  logic prot_n;
  logic permit_drop;

  function automatic logic one_or_none(input logic [13:0] v);
    return (v & (v - 14'h1)) == 14'h0;
  endfunction : one_or_none

  // Pins are asynchronous to clk_sys_i; two stages before any use
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hw_sync_q <= 2'b00;
      en_sync_q <= 2'b00;
    end else begin
      hw_sync_q <= {hw_sync_q[0], hw_write_permit_i};
      en_sync_q <= {en_sync_q[0], flash_enable_i};
    end
  end

  assign hw_permit = hw_sync_q[1];
  assign flash_en = en_sync_q[1];

  assign req = {avs_address_i, avs_read_i, avs_write_i, avs_byteenable_i, avs_writedata_i};

  // Every access, mapped or not, takes the same fixed number of cycles.
  // Held off in the answer cycle, where the master still holds its request.
  fpec_bus_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .req_i((req.read | req.write) & avs_waitrequest_o),
    .last_o(acc_last),
    .waitrequest_o(wait_int)
  );

  // Byte lane must be enabled; disabled flash discards writes
  assign wr_ok = acc_last & req.write & req.byteenable & flash_en;
  assign rd_ok = acc_last & req.read;

  // Error protection: error flag blocks both start bits
  assign prot_n = hw_permit & ~err_flag_q;

  // Clearing the software permit drops modes and selects at the same edge
  assign permit_drop = wr_ok && req.address == OFS_MODE_CTRL && !req.writedata[BIT_SW_PERMIT];

  // Software permit clears itself while the pin is low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || hw_standby_i || sw_standby_i) begin
      sw_permit_q <= 1'b0;
    end else if (!hw_permit) begin
      sw_permit_q <= 1'b0;
    end else if (wr_ok && req.address == OFS_MODE_CTRL) begin
      sw_permit_q <= req.writedata[BIT_SW_PERMIT];
    end
  end

  // Mode bits; gating uses the state before this write, so bits set together fail
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || hw_standby_i || sw_standby_i) begin
      mode_q <= '0;
    end else if (!hw_permit || !sw_permit_q || permit_drop) begin
      mode_q <= '0;
    end else begin
      if (wr_ok && req.address == OFS_MODE_CTRL) begin
        mode_q.erase_setup <= req.writedata[BIT_ERASE_SETUP];
        mode_q.program_setup <= req.writedata[BIT_PROG_SETUP];
        mode_q.erase_verify <= req.writedata[BIT_ERASE_VERIFY];
        mode_q.program_verify <= req.writedata[BIT_PROG_VERIFY];
        // A write refused for a clear setup bit leaves the start bit as it was
        if (mode_q.erase_setup && !err_flag_q) begin
          mode_q.erase_start <= req.writedata[BIT_ERASE_START];
        end
        if (mode_q.program_setup && !err_flag_q) begin
          mode_q.program_start <= req.writedata[BIT_PROG_START];
        end
      end
      if (err_flag_q) begin
        mode_q.erase_start <= 1'b0;
        mode_q.program_start <= 1'b0;
      end
    end
  end

  // Error flag: set by an error during program or erase; cleared only by hard resets
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || hw_standby_i) begin
      err_flag_q <= 1'b0;
    end else if (flash_error_event_i && (mode_q.erase_start || mode_q.program_start)) begin
      err_flag_q <= 1'b1;
    end
  end

  // Block select next values with the one-hot check over both registers
  assign sel_wr = wr_ok && (req.address == OFS_SMALL_SEL || req.address == OFS_LARGE_SEL);

  always_comb begin
    small_sel_d = small_sel_q;
    large_sel_d = large_sel_q;
    if (wr_ok && req.address == OFS_SMALL_SEL) begin
      small_sel_d = req.writedata;
    end
    if (wr_ok && req.address == OFS_LARGE_SEL) begin
      large_sel_d = req.writedata[LARGE_BLOCKS-1:0];
    end
    if (sel_wr && !one_or_none({large_sel_d, small_sel_d})) begin
      small_sel_d = RST_ZERO;
      large_sel_d = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || hw_standby_i || sw_standby_i || !hw_permit || !sw_permit_q ||
        permit_drop) begin
      small_sel_q <= RST_ZERO;
      large_sel_q <= '0;
    end else begin
      small_sel_q <= small_sel_d;
      large_sel_q <= large_sel_d;
    end
  end

  assign ctrl_rd = {hw_permit, sw_permit_q, mode_q.erase_setup, mode_q.program_setup,
                    mode_q.erase_verify, mode_q.program_verify, mode_q.erase_start,
                    mode_q.program_start};

  always_comb begin
    rd_d = RD_UNMAPPED;
    if (flash_en) begin
      case (req.address)
        OFS_MODE_CTRL: rd_d = ctrl_rd;
        OFS_ERR_STAT: rd_d = {err_flag_q, 7'h00};
        OFS_SMALL_SEL: rd_d = small_sel_q;
        OFS_LARGE_SEL: rd_d = {2'b00, large_sel_q};
        default: rd_d = RD_UNMAPPED;
      endcase
    end else begin
      rd_d = RD_UNMAPPED;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= RST_ZERO;
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(wait_int == 1'b1 && !acc_last) & ~wait_int ? 1'b0 : 1'b1;
      if (rd_ok) begin
        avs_readdata_o <= rd_d;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_o <= '0;
      sw_write_permit_o <= 1'b0;
      small_block_erase_o <= RST_ZERO;
      large_block_erase_o <= '0;
      flash_error_flag_o <= 1'b0;
    end else begin
      mode_o <= mode_q;
      mode_o.erase_start <= mode_q.erase_start & prot_n;
      mode_o.program_start <= mode_q.program_start & prot_n;
      sw_write_permit_o <= sw_permit_q;
      small_block_erase_o <= small_sel_q;
      large_block_erase_o <= large_sel_q;
      flash_error_flag_o <= err_flag_q;
    end
  end
endmodule : fpec_top

/* File: verif/fpec_assertions.sv */
// Port-level checker for the flash program/erase control block.
// Bound to fpec_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
module fpec_chk import fpec_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Bus
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // System and outputs
  input wire logic flash_enable_i,
  input wire logic hw_standby_i,
  input fpec_mode_t mode_o,
  input wire logic sw_write_permit_o,
  input wire logic [7:0] small_block_erase_o,
  input wire logic [LARGE_BLOCKS-1:0] large_block_erase_o,
  input wire logic flash_error_flag_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Long disabled spell, so the pin synchroniser has settled
  logic [2:0] dis_cnt_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || flash_enable_i) begin
      dis_cnt_q <= 3'h0;
    end else if (dis_cnt_q != 3'h7) begin
      dis_cnt_q <= dis_cnt_q + 3'h1;
    end
  end
  err_low_zero_a: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_ERR_STAT
    |-> avs_readdata_o[6:0] == 7'h00) else $error("status low bits set");
  block_onehot_a: assert property (
    $onehot0({small_block_erase_o, large_block_erase_o})) else $error("two blocks selected");
  start_blocked_a: assert property (
    flash_error_flag_o |-> !mode_o.program_start && !mode_o.erase_start)
    else $error("start while error flag");
  permit_gates_a: assert property (
    !sw_write_permit_o |-> mode_o == '0 && small_block_erase_o == 8'h00)
    else $error("mode or select without permit");
  flag_sticky_a: assert property (
    flash_error_flag_o && !hw_standby_i && !$past(hw_standby_i) |=> flash_error_flag_o)
    else $error("error flag lost");
  wait_single_a: assert property (
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o) else $error("answer longer than a cycle");
  access_len_a: assert property (
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o [*3] ##[1:2] !avs_waitrequest_o)
    else $error("access length wrong");
  disabled_zero_a: assert property (
    avs_read_i && !avs_waitrequest_o && dis_cnt_q == 3'h7 |-> avs_readdata_o == 8'h00)
    else $error("read nonzero while disabled");
endmodule : fpec_chk

bind fpec_top fpec_chk i_fpec_chk (.clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .flash_enable_i, .hw_standby_i, .mode_o,
  .sw_write_permit_o, .small_block_erase_o, .large_block_erase_o, .flash_error_flag_o);

/* File: verif/tb_top.sv */
// Self-checking bench for fpec_top over its Avalon-MM slave.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb_top;
  import fpec_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_byteenable_i = 1'b1;
  logic [7:0] avs_writedata_i = 8'h00, avs_readdata_o, small_block_erase_o, m;
  logic avs_waitrequest_o, sw_write_permit_o, flash_error_flag_o;
  logic hw_write_permit_i = 1'b0, flash_enable_i = 1'b1, hw_standby_i = 1'b0;
  logic sw_standby_i = 1'b0, flash_error_event_i = 1'b0;
  fpec_mode_t mode_o;
  logic [LARGE_BLOCKS-1:0] large_block_erase_o;
  int err_total = 0, checks_done = 0, seed = 67, k, j;
  // Mode steps from the pin-high state, with start writes refused while their setup bit is clear
  logic [7:0] seq [18] = '{8'h60, 8'h41, 8'h42, 8'h50, 8'h51, 8'h50, 8'h40, 8'h60, 8'h61,
    8'h62, 8'h60, 8'h40, 8'h48, 8'h40, 8'h44, 8'h40, 8'h50, 8'h51};
  fpec_top i_fpec_top (.clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .hw_write_permit_i, .flash_enable_i, .hw_standby_i, .sw_standby_i, .flash_error_event_i,
    .mode_o, .sw_write_permit_o, .small_block_erase_o, .large_block_erase_o,
    .flash_error_flag_o);
  always #4 clk_sys_i = ~clk_sys_i;
  // Control register after a write with the pin high; gating uses the old value
  function automatic logic [7:0] ctrl_next(input logic [7:0] o, input logic [7:0] w);
    ctrl_next = {1'b1, w[6], o[6] ? w[5:2] : o[5:2], (o[6] & o[5]) ? w[1] : o[1],
      (o[6] & o[4]) ? w[0] : o[0]};
    if (!w[6]) begin
      ctrl_next[5:0] = 6'h00;
    end
  endfunction : ctrl_next
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 20) begin
      $display("ERROR waitrequest expected 0 seen %b", avs_waitrequest_o);
      err_total++;
      finish_test();
    end
  endtask : bus
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    cmp(nm, e, x);
  endtask : rd
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(OFS_MODE_CTRL, RST_ZERO, "ctrl pin low");
    wr(OFS_MODE_CTRL, 8'h40);
    rd(OFS_MODE_CTRL, RST_ZERO, "permit pin low");
    hw_write_permit_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_MODE_CTRL, RST_CTRL_PIN_HIGH, "ctrl pin high");
    m = RST_CTRL_PIN_HIGH;
    foreach (seq[i]) begin
      wr(OFS_MODE_CTRL, seq[i]);
      m = ctrl_next(m, seq[i]);
      rd(OFS_MODE_CTRL, m, "ctrl");
      cmp("mode", {2'b00, m[0], m[1], m[2], m[3], m[4], m[5]}, {2'b00, mode_o});
      cmp("permit out", {7'h00, m[6]}, {7'h00, sw_write_permit_o});
    end
    flash_error_event_i <= 1'b1;
    @(posedge clk_sys_i);
    flash_error_event_i <= 1'b0;
    rd(OFS_ERR_STAT, 8'h80, "error flag");
    cmp("starts", 8'h00, {6'h00, mode_o.program_start, mode_o.erase_start});
    cmp("flag out", 8'h01, {7'h00, flash_error_flag_o});
    wr(OFS_ERR_STAT, 8'($random(seed)) & 8'h80);
    rd(OFS_ERR_STAT, 8'h80, "flag after write");
    sw_standby_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_standby_i <= 1'b0;
    rd(OFS_ERR_STAT, 8'h80, "flag sw standby");
    rd(OFS_MODE_CTRL, RST_CTRL_PIN_HIGH, "ctrl sw standby");
    hw_standby_i <= 1'b1;
    @(posedge clk_sys_i);
    hw_standby_i <= 1'b0;
    rd(OFS_ERR_STAT, RST_ZERO, "flag hw standby");
    cmp("flag out clear", 8'h00, {7'h00, flash_error_flag_o});
    wr(OFS_MODE_CTRL, 8'h40);
    repeat (4) begin
      k = {$random(seed)} % 8;
      j = {$random(seed)} % LARGE_BLOCKS;
      wr(OFS_SMALL_SEL, 8'h01 << k);
      rd(OFS_SMALL_SEL, 8'h01 << k, "small select");
      cmp("small out", 8'h01 << k, small_block_erase_o);
      wr(OFS_LARGE_SEL, 8'hC0 | (8'h01 << j));
      rd(OFS_SMALL_SEL, RST_ZERO, "two selects");
      wr(OFS_LARGE_SEL, 8'hC0 | (8'h01 << j));
      rd(OFS_LARGE_SEL, 8'h01 << j, "large select");
      cmp("large out", 8'h01 << j, {2'b00, large_block_erase_o});
      wr(OFS_LARGE_SEL, RST_ZERO);
    end
    wr(OFS_SMALL_SEL, 8'h03);
    rd(OFS_SMALL_SEL, RST_ZERO, "multi bit");
    avs_byteenable_i <= 1'b0;
    wr(OFS_SMALL_SEL, 8'h01);
    avs_byteenable_i <= 1'b1;
    rd(OFS_SMALL_SEL, RST_ZERO, "no byteenable");
    rd(4'h2, RD_UNMAPPED, "unmapped");
    wr(OFS_SMALL_SEL, 8'h80);
    wr(OFS_MODE_CTRL, RST_ZERO);
    rd(OFS_SMALL_SEL, RST_ZERO, "select no permit");
    flash_enable_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rd(OFS_MODE_CTRL, RST_ZERO, "disabled read");
    wr(OFS_MODE_CTRL, 8'h40);
    flash_enable_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_MODE_CTRL, RST_CTRL_PIN_HIGH, "disabled write");
    hw_write_permit_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_MODE_CTRL, RST_ZERO, "pin dropped");
    finish_test();
  end
endmodule : tb_top
